//--- shared/adbc_pkg.sv
// Shared constants and types for the backplane DRAM board controller.
// Assumes a 20 MHz system clock and an APB master for the settings registers.
package adbc_pkg;

  // Timebase and refresh figures
  localparam int CLK_NS         = 50;
  localparam int REFRESH_NOM_NS = 16000;
  localparam int RETENTION_NS   = 2000000;
  localparam int REF_CYCLE_NS   = 460;
  localparam int REF_ROWS       = 128;
  localparam int REF_NOM_CYC    = REFRESH_NOM_NS / CLK_NS;
  localparam int REF_BUSY_CYC   = (REF_CYCLE_NS + CLK_NS - 1) / CLK_NS;

  // Address space, in words unless noted
  localparam int ADDR_W      = 18;
  localparam int WORD_W      = 17;
  localparam int DATA_W      = 16;
  localparam int MEM_WORDS   = 2 ** WORD_W;
  localparam int BLOCK_SHIFT = 12;
  localparam logic [17:0] IO_BASE   = 18'h1_f000;
  localparam logic [17:0] SPACE_TOP = 18'h2_0000;
  localparam logic [17:0] IO_2K     = 18'h0_0800;
  localparam logic [17:0] IO_4K     = 18'h0_1000;
  localparam logic [17:0] IO_8K     = 18'h0_2000;
  // Parity status word, byte address
  localparam logic [17:0] CSR_BASE  = 18'h3_f440;
  localparam int CSR_ERR_BIT   = 15;
  localparam int CSR_WRONG_BIT = 2;
  localparam int CSR_EN_BIT    = 0;

  // Cycle type after the active-low control pins are inverted
  localparam logic [1:0] CYC_READ       = 2'h0;
  localparam logic [1:0] CYC_READ_PAUSE = 2'h1;
  localparam logic [1:0] CYC_WRITE      = 2'h2;
  localparam logic [1:0] CYC_WRITE_BYTE = 2'h3;

  // APB register offsets
  localparam logic [11:0] REG_CFG  = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;

  // Board settings, low field in the low bits
  typedef struct packed {
    logic       fitted;
    logic       ext_par;
    logic       ext_ref;
    logic [3:0] csr_sel;
    logic [2:0] io_size;
    logic [2:0] cap;
    logic [4:0] base;
  } adbc_cfg_s;
  localparam logic [17:0] CFG_RST = 18'h2_0000;

  // Board state visible to software
  typedef struct packed {
    logic        pend;
    logic        err;
    logic [6:0]  row;
    logic [15:0] count;
  } adbc_stat_s;

  // Backplane pins as seen at the board edge, all active low
  typedef struct packed {
    logic [17:0] addr_n;
    logic [15:0] data_n;
    logic [1:0]  ctl_n;
    logic        master_sync_strobe_n;
    logic [1:0]  par_n;
    logic        external_parity_present_n;
    logic        ext_ref_n;
  } adbc_pins_s;

  typedef enum logic [1:0] {ST_IDLE, ST_REFRESH, ST_ACCESS, ST_REPLY} adbc_state_e;

  // Capacity code to 4K-word blocks: 32K, 48K, 64K, 96K, 128K
  function automatic logic [5:0] cap_blocks(input logic [2:0] code);
    case (code)
      3'h0:    cap_blocks = 6'h08;
      3'h1:    cap_blocks = 6'h0c;
      3'h2:    cap_blocks = 6'h10;
      3'h3:    cap_blocks = 6'h18;
      3'h4:    cap_blocks = 6'h20;
      default: cap_blocks = 6'h00;
    endcase
  endfunction : cap_blocks

  // Three switches; the largest closed one wins
  function automatic logic [17:0] io_words(input logic [2:0] sw);
    if (sw[2])      io_words = IO_8K;
    else if (sw[1]) io_words = IO_4K;
    else if (sw[0]) io_words = IO_2K;
    else            io_words = 18'h0_0000;
  endfunction : io_words

endpackage : adbc_pkg

//--- src/adbc_sync.sv
// Three-stage synchroniser for a group of asynchronous pins.
// Assumes the pins may change at any time relative to the system clock.
`timescale 1ns/1ps
module adbc_sync #(
  parameter int           W     = 1,
  parameter logic [W-1:0] P_RST = '1
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  // Pins in, filtered copy out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Chain; stage one feeds stage two only
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= P_RST;
      s2 <= P_RST;
      s3 <= P_RST;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit moves only once stages two and three agree, which drops runt glitches
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_q[g] <= P_RST[g];
        end else if (s2[g] == s3[g]) begin
          o_q[g] <= s3[g];
        end
      end
    end
  endgenerate

endmodule : adbc_sync

//--- src/adbc_top.sv
// Control logic of a DRAM memory board on an asynchronous backplane bus.
// Assumes board pins arrive unsynchronised and settings come over APB.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps

module adbc_top
  import adbc_pkg::*;
#(
  parameter int RETENTION_CYC = adbc_pkg::RETENTION_NS / adbc_pkg::CLK_NS
) (
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_n,
  // APB slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [11:0]          i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // Backplane inputs
  input  wire adbc_pkg::adbc_pins_s i_pins,
  // Backplane outputs, active low, with enables
  output logic      [15:0]          o_data_n,
  output logic                      o_data_oe,
  output logic      [1:0]           o_par_n,
  output logic                      o_par_oe,
  output logic                      o_slave_sync_strobe_n,
  output logic                      o_internal_slave_sync_ext_parity_n,
  output logic                      o_pb_n
);
  import adbc_pkg::*;

  localparam int PER_RET    = RETENTION_CYC / REF_ROWS;
  localparam int PER_RAW    = (REF_NOM_CYC < PER_RET) ? REF_NOM_CYC : PER_RET;
  localparam int REF_PERIOD = (PER_RAW < 1) ? 1 : PER_RAW;
  localparam int A_BUSY     = REF_BUSY_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture
  adbc_pins_s  pins_q;
  adbc_cfg_s   cfg;
  adbc_state_e st;
  adbc_state_e next_st;

  adbc_sync #(
    .W     ($bits(adbc_pins_s)),
    .P_RST ('1)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_d       (i_pins),
    .o_q       (pins_q)
  );

  logic              master_sync_strobe;
  logic [17:0]       addr;
  logic [15:0]       wdata;
  logic [1:0]        cyc;
  logic              ext_ref_req;
  logic              external_parity_present;
  // Every pin is read as asserted when low
  assign master_sync_strobe        = ~pins_q.master_sync_strobe_n;
  assign addr        = ~pins_q.addr_n;
  assign wdata       = ~pins_q.data_n;
  assign cyc         = ~pins_q.ctl_n;
  assign ext_ref_req = ~pins_q.ext_ref_n;
  assign external_parity_present     = ~pins_q.external_parity_present_n;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [17:0]       wa;
  logic [17:0]       lo;
  logic [17:0]       hi;
  logic [17:0]       lim_raw;
  logic [17:0]       limit;
  logic [17:0]       csr_addr;
  logic [WORD_W-1:0] idx;
  logic              ext_par_mode;
  logic              mem_hit;
  logic              csr_hit;
  logic              is_write;
  logic              is_byte;

  // Plain variant is forced into external parity mode
  assign ext_par_mode = cfg.ext_par | ~cfg.fitted;
  assign wa       = {1'b0, addr[17:1]};
  assign lo       = 18'(cfg.base) << BLOCK_SHIFT;
  assign hi       = lo + (18'(cap_blocks(cfg.cap)) << BLOCK_SHIFT);
  assign lim_raw  = IO_BASE + io_words(cfg.io_size);
  assign limit    = (lim_raw > SPACE_TOP) ? SPACE_TOP : lim_raw;
  assign csr_addr = CSR_BASE + (18'(cfg.csr_sel) << 1);
  assign csr_hit  = !ext_par_mode && addr[17:1] == csr_addr[17:1];
  // Above the limit only the status word answers; the 18-bit sum cannot wrap to the base
  assign mem_hit  = wa >= lo && wa < hi && wa < limit && !csr_hit;
  assign idx      = WORD_W'(wa - lo);
  assign is_write = cyc == CYC_WRITE || cyc == CYC_WRITE_BYTE;
  assign is_byte  = cyc == CYC_WRITE_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // Storage, two parity bits above the data word
  logic [17:0] mem [0:MEM_WORDS-1];
  logic [17:0] mem_q;
  logic [15:0] csr;
  logic [1:0]  gen_p;
  logic        perr;
  logic [15:0] rd_val;

  assign mem_q  = mem[idx];
  // Odd parity per byte; the test bit stores it inverted on purpose
  assign gen_p  = {~^wdata[15:8], ~^wdata[7:0]}
                ^ {2{csr[CSR_WRONG_BIT] & !ext_par_mode}};
  // Checked in the same cycle as the array read, so no extra wait state
  assign perr   = cfg.fitted && (mem_q[17:16] != {~^mem_q[15:8], ~^mem_q[7:0]});
  assign rd_val = csr_hit ? csr : mem_q[15:0];

  // Byte writes leave the other byte and its parity bit alone
  always_ff @(posedge i_clk_sys) begin
    if (st == ST_ACCESS && mem_hit && is_write) begin
      if (!is_byte || !addr[0]) begin
        mem[idx][7:0] <= wdata[7:0];
        mem[idx][16]  <= gen_p[0];
      end
      if (!is_byte || addr[0]) begin
        mem[idx][15:8] <= wdata[15:8];
        mem[idx][17]   <= gen_p[1];
      end
    end
  end

  // Parity status word; a new error beats a software clear
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      csr <= 16'h0000;
    end else begin
      if (st == ST_ACCESS && csr_hit && is_write) begin
        if (!is_byte || !addr[0]) begin
          csr[CSR_WRONG_BIT] <= wdata[CSR_WRONG_BIT];
          csr[CSR_EN_BIT]    <= wdata[CSR_EN_BIT];
        end
        if (!is_byte || addr[0]) begin
          csr[CSR_ERR_BIT] <= wdata[CSR_ERR_BIT];
        end
      end
      if (st == ST_ACCESS && mem_hit && !is_write && perr && !ext_par_mode) begin
        csr[CSR_ERR_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh timing
  logic [15:0] ref_timer;
  logic [15:0] busy_cnt;
  logic [15:0] gap_cnt;
  logic [15:0] ref_count;
  logic [6:0]  ref_row;
  logic        ref_pend;
  logic        ref_prev;
  logic        ref_tick;
  logic        ref_ext_edge;
  logic        ref_take;

  assign ref_tick     = !cfg.ext_ref && ref_timer == 16'(REF_PERIOD - 1);
  assign ref_ext_edge = cfg.ext_ref && ext_ref_req && !ref_prev;
  assign ref_take     = st == ST_IDLE && ref_pend;

  // Spacing keeps all rows inside the retention window
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_timer <= 16'h0000;
    end else if (cfg.ext_ref || ref_tick) begin
      ref_timer <= 16'h0000;
    end else begin
      ref_timer <= ref_timer + 16'h0001;
    end
  end

  // Request flag: a new request wins over the take in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_pend <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= ext_ref_req;
      ref_pend <= ref_tick | ref_ext_edge | (ref_pend & ~ref_take);
    end
  end

  // Row address and counters for status and checks
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_row   <= 7'h00;
      ref_count <= 16'h0000;
      gap_cnt   <= 16'h0000;
    end else begin
      if (ref_take) begin
        ref_row   <= ref_row + 7'h01;
        ref_count <= ref_count + 16'h0001;
      end
      if (ref_take || cfg.ext_ref) begin
        gap_cnt <= 16'h0000;
      end else if (gap_cnt != 16'hffff) begin
        gap_cnt <= gap_cnt + 16'h0001;
      end
    end
  end

  // Refresh lasts one read cycle time; this is also the worst bus delay
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt <= 16'h0000;
    end else if (st == ST_REFRESH) begin
      busy_cnt <= busy_cnt + 16'h0001;
    end else begin
      busy_cnt <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer
  always_comb begin
    next_st = st;
    unique case (st)
      // A pending refresh goes first; a started cycle is never cut short
      ST_IDLE: begin
        if (ref_pend) begin
          next_st = ST_REFRESH;
        end else if (master_sync_strobe && (mem_hit || csr_hit)) begin
          next_st = ST_ACCESS;
        end
      end
      ST_REFRESH: begin
        if (busy_cnt == 16'(REF_BUSY_CYC - 1)) begin
          next_st = ST_IDLE;
        end
      end
      ST_ACCESS: begin
        next_st = ST_REPLY;
      end
      ST_REPLY: begin
        if (!master_sync_strobe) begin
          next_st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Reply pins; in external parity mode on a parity-fitted board, a present parity module's own sync goes to the master
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_slave_sync_strobe_n     <= 1'b1;
      o_internal_slave_sync_ext_parity_n <= 1'b1;
      o_pb_n       <= 1'b1;
      o_data_n     <= 16'hffff;
      o_data_oe    <= 1'b0;
      o_par_n      <= 2'h3;
      o_par_oe     <= 1'b0;
    end else if (st == ST_ACCESS) begin
      o_slave_sync_strobe_n     <= ext_par_mode && external_parity_present && cfg.fitted;
      o_internal_slave_sync_ext_parity_n <= !(ext_par_mode && external_parity_present && cfg.fitted);
      o_pb_n       <= !(mem_hit && !is_write && perr && !ext_par_mode
                        && csr[CSR_EN_BIT]);
      o_data_n     <= ~rd_val;
      o_data_oe    <= !is_write;
      o_par_n      <= ~mem_q[17:16];
      o_par_oe     <= !is_write && mem_hit && ext_par_mode && cfg.fitted;
    end else if (st == ST_REPLY && !master_sync_strobe) begin
      o_slave_sync_strobe_n     <= 1'b1;
      o_internal_slave_sync_ext_parity_n <= 1'b1;
      o_pb_n       <= 1'b1;
      o_data_oe    <= 1'b0;
      o_par_oe     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state; every answer comes from a flop loaded in the setup phase
  adbc_stat_s stat;
  logic       apb_done;
  assign stat     = '{pend: ref_pend, err: csr[CSR_ERR_BIT], row: ref_row, count: ref_count};
  assign apb_done = i_psel && i_penable && o_pready;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel && !i_penable && !o_pready;
      o_pslverr <= i_psel && !i_penable && i_paddr != REG_CFG && i_paddr != REG_STAT;
      if (i_psel && !i_penable) begin
        if (i_paddr == REG_CFG) begin
          o_prdata <= 32'(cfg);
        end else if (i_paddr == REG_STAT) begin
          o_prdata <= 32'(stat);
        end else begin
          o_prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Settings are switch images; change them only while the bus is quiet
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= CFG_RST;
    end else if (apb_done && i_pwrite && i_paddr == REG_CFG) begin
      cfg <= i_pwdata[$bits(adbc_cfg_s)-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_slave_sync_strobe_release;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      st == ST_REPLY && !master_sync_strobe |=> o_slave_sync_strobe_n && o_internal_slave_sync_ext_parity_n;
  endproperty
  a_slave_sync_strobe_release: assert property (p_slave_sync_strobe_release) else $error("sync not released");

  property p_no_delay;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      st == ST_IDLE && next_st == ST_ACCESS |=> ##1 (!o_slave_sync_strobe_n || !o_internal_slave_sync_ext_parity_n);
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("reply late");

  property p_refresh_len;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(st == ST_REFRESH) |-> ##A_BUSY st != ST_REFRESH;
  endproperty
  a_refresh_len: assert property (p_refresh_len) else $error("refresh length wrong");

  property p_pend_served;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      st == ST_IDLE && ref_pend |=> st == ST_REFRESH;
  endproperty
  a_pend_served: assert property (p_pend_served) else $error("refresh not started");

  property p_tick;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !cfg.ext_ref && ref_timer == 16'(REF_PERIOD - 1) |=> ref_pend && ref_timer == 16'h0000;
  endproperty
  a_tick: assert property (p_tick) else $error("refresh tick missed");

  property p_retention;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      st == ST_IDLE && !ref_pend && !cfg.ext_ref |-> gap_cnt <= 16'(REF_PERIOD);
  endproperty
  a_retention: assert property (p_retention) else $error("refresh gap too long");

  property p_ext_ref;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      cfg.ext_ref && $past(cfg.ext_ref) && !$past(ref_ext_edge) && !$past(ref_pend)
      |-> !ref_pend;
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("unrequested refresh");

  property p_no_wrap;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(!o_slave_sync_strobe_n || !o_internal_slave_sync_ext_parity_n) && !$past(csr_hit)
      |-> $past(wa) < limit && $past(wa) >= lo && $past(wa) < hi;
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("answer outside window");

  property p_byte_keep;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      st == ST_ACCESS && mem_hit && is_byte && addr[0]
      |=> mem[$past(idx)][7:0] == $past(mem_q[7:0]);
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("other byte changed");

  property p_pb;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !o_pb_n |-> !o_slave_sync_strobe_n && o_data_oe && !ext_par_mode;
  endproperty
  a_pb: assert property (p_pb) else $error("parity error line misused");

endmodule : adbc_top

//--- bench/adbc_master.sv
// Bus master model that drives the backplane pins of the DRAM board.
// Assumes the board replies within 40 clocks; a silent board gives ok=0.
`timescale 1ns/1ps
module adbc_master
  import adbc_pkg::*;
(
  // Clock, board outputs, and the bench's refresh request and parity-module presence lines
  input  wire logic            i_clk_sys,
  input  wire logic [15:0]     i_data_n,
  input  wire logic            i_data_oe,
  input  wire logic            i_slave_sync_strobe_n,
  input  wire logic            i_internal_slave_sync_ext_parity_n,
  input  wire logic            i_pb_n,
  input  wire logic            i_ext_ref_n,
  input  wire logic            i_external_parity_present_n,
  // Pins toward the board
  output adbc_pkg::adbc_pins_s o_pins
);
  logic [17:0] addr_n = '1;
  logic [1:0]  ctl_n  = '1;
  logic        master_sync_strobe_n = 1'b1;
  logic        wr     = 1'b0;
  logic [15:0] wdat_n = '1;
  logic [15:0] bus_n;

  ////////////////////////////////////////////////////////////////////////////
  // Released data lines float up to the terminator level, read as deasserted
  assign bus_n = wr ? wdat_n : (i_data_oe ? i_data_n : '1);
  // All lines low-true; the bench says whether a parity module sits on the bus
  assign o_pins = '{addr_n: addr_n, data_n: bus_n, ctl_n: ctl_n, master_sync_strobe_n: master_sync_strobe_n,
                    par_n: 2'b11, external_parity_present_n: i_external_parity_present_n, ext_ref_n: i_ext_ref_n};

  ////////////////////////////////////////////////////////////////////////////
  // One handshake; address, type and data held until the reply
  task automatic cycle(input logic [17:0] a, input logic [1:0] c, input logic [15:0] d,
                       output logic [15:0] q, output logic pb, output logic ok);
    int n;
    @(posedge i_clk_sys);
    addr_n <= ~a;
    ctl_n  <= ~c;
    wr     <= c[1];
    wdat_n <= ~d;
    // Two clocks cover the address setup time
    repeat (2) @(posedge i_clk_sys);
    master_sync_strobe_n <= 1'b0;
    ok = 1'b0;
    // Reply, data and error line are taken at the edge that sees the sync
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge i_clk_sys);
      ok = (i_slave_sync_strobe_n === 1'b0) || (i_internal_slave_sync_ext_parity_n === 1'b0);
    end
    q  = ~i_data_n;
    pb = (i_pb_n === 1'b0);
    master_sync_strobe_n <= 1'b1;
    for (n = 0; n < 40 && (i_slave_sync_strobe_n === 1'b0 || i_internal_slave_sync_ext_parity_n === 1'b0); n++)
      @(posedge i_clk_sys);
    ok = ok && (n < 40);
    @(posedge i_clk_sys);
    addr_n <= '1;
    ctl_n  <= '1;
    wr     <= 1'b0;
  endtask : cycle
endmodule : adbc_master

//--- bench/adbc_top_test.sv
// Self-checking bench for the backplane DRAM board controller.
// Assumes 20 MHz; refresh spacing shortened to 20 clocks through RETENTION_CYC.
`timescale 1ns/1ps
module adbc_top_test;
  import adbc_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, ext_ref_n = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, top, lim;
  logic        pready, pslverr, e, data_oe, slave_sync_strobe_n, internal_slave_sync_ext_parity_n, pb_n, bpb, bok;
  logic        external_parity_present_n = 1'b1, par_oe;
  logic [1:0]  par_n;
  logic [3:0]  par_seen = '0;
  logic [15:0] data_n, bq, c0;
  logic [2:0]  sw;
  adbc_pins_s  pins;
  int          error_cnt = 0, samples_checked = 0;
  int          blk[5] = '{8, 12, 16, 24, 32};

  always #25 clk = ~clk;

  // Period 20 leaves room for bus cycles between refreshes; 10 would starve them
  adbc_top #(.RETENTION_CYC(2560)) dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pins(pins),
    .o_data_n(data_n), .o_data_oe(data_oe), .o_par_n(par_n), .o_par_oe(par_oe),
    .o_slave_sync_strobe_n(slave_sync_strobe_n), .o_internal_slave_sync_ext_parity_n(internal_slave_sync_ext_parity_n), .o_pb_n(pb_n));
  adbc_master m (.i_clk_sys(clk), .i_data_n(data_n), .i_data_oe(data_oe), .i_slave_sync_strobe_n(slave_sync_strobe_n),
    .i_internal_slave_sync_ext_parity_n(internal_slave_sync_ext_parity_n), .i_pb_n(pb_n), .i_ext_ref_n(ext_ref_n),
    .i_external_parity_present_n(external_parity_present_n), .o_pins(pins));
  // What a parity module sees while its own sync is low: board sync, parity drive, bits
  always @(posedge clk) if (internal_slave_sync_ext_parity_n === 1'b0) par_seen <= {slave_sync_strobe_n, par_oe, ~par_n};

  ////////////////////////////////////////////////////////////////////////////
  // Compare and closing report
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // APB transfer; answer taken and request released at the edge that samples pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
    if (n == 20) begin
      error_cnt++;
      give_verdict;
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic bus(input logic [17:0] a, input logic [1:0] c, input logic [15:0] d);
    m.cycle(a, c, d, bq, bpb, bok);
  endtask : bus
  // Board settings word with parity fitted
  function automatic logic [31:0] cfgv(input logic [4:0] b, input logic [2:0] c,
                                       input logic [2:0] io);
    cfgv = 32'h0002_0000 | {21'h0, io, c, b};
  endfunction : cfgv

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, REG_CFG, 32'h0);
    chk("cfg reset", {14'h0, CFG_RST}, q);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped error", 32'h1, e);
    apb(1'b1, REG_CFG, cfgv(5'd1, 3'd0, 3'd0));
    bus(18'h0_2000, CYC_WRITE, 16'h1234);
    chk("write reply", 32'h1, bok);
    bus(18'h0_2001, CYC_WRITE_BYTE, 16'hab00);
    bus(18'h0_2000, CYC_WRITE_BYTE, 16'h00cd);
    bus(18'h0_2000, CYC_READ, 16'h0);
    chk("byte merge", 32'habcd, bq);
    chk("good parity", 32'h0, bpb);
    bus(18'h0_1ffe, CYC_READ, 16'h0);
    chk("below base", 32'h0, bok);
    // Each capacity ends at its size or at the I/O page
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, REG_CFG, cfgv(5'd0, 3'(k), 3'd0));
      top = (blk[k] * 32'h2000 < 32'h3_e000) ? blk[k] * 32'h2000 : 32'h3_e000;
      bus(top[17:0] - 18'd2, CYC_READ, 16'h0);
      chk("last word", 32'h1, bok);
      bus(top[17:0], CYC_READ, 16'h0);
      chk("past end", 32'h0, bok);
    end
    // High base: truncation without wrap, then each I/O slice
    for (int k = 0; k < 4; k++) begin
      sw  = (k == 0) ? 3'd0 : 3'(1 << (k - 1));
      lim = 32'h1_f000 + ((k == 0) ? 32'h0 : (32'h400 << k));
      lim = (lim > 32'h2_0000) ? 32'h2_0000 : lim;
      apb(1'b1, REG_CFG, cfgv(5'd28, 3'd4, sw));
      bus(18'(2 * lim - 2), CYC_READ, 16'h0);
      chk("slice last", 32'h1, bok);
      if (lim < 32'h2_0000) begin
        bus(18'(2 * lim), CYC_READ, 16'h0);
        chk("slice end", 32'h0, bok);
      end
    end
    // Status word forces wrong parity and enables the error line
    apb(1'b1, REG_CFG, cfgv(5'd0, 3'd0, 3'd0));
    bus(CSR_BASE, CYC_WRITE, 16'h0005);
    bus(18'h0_0100, CYC_WRITE, 16'h5a5a);
    bus(18'h0_0100, CYC_READ, 16'h0);
    chk("bad parity data", 32'h5a5a, bq);
    chk("bad parity flag", 32'h1, bpb);
    bus(CSR_BASE, CYC_READ, 16'h0);
    chk("status word", 32'h8005, bq);
    bus(CSR_BASE + 18'd2, CYC_READ, 16'h0);
    chk("status one word", 32'h0, bok);
    // Error line still enabled, correct parity stored: no error reported
    bus(CSR_BASE, CYC_WRITE, 16'h0001);
    bus(18'h0_0100, CYC_WRITE, 16'h5a5a);
    bus(18'h0_0100, CYC_READ, 16'h0);
    chk("good parity flag", 32'h0, bpb);
    apb(1'b1, REG_CFG, cfgv(5'd0, 3'd0, 3'd0) | 32'h1_0000);
    bus(CSR_BASE, CYC_READ, 16'h0);
    chk("status ext mode", 32'h0, bok);
    // Parity module present: it gets the sync; odd parity of 16'h0001 is high 1, low 0
    external_parity_present_n <= 1'b0;
    bus(18'h0_0200, CYC_WRITE, 16'h0001);
    bus(18'h0_0200, CYC_READ, 16'h0);
    chk("int sync reply", 32'h1, bok);
    chk("ext parity pins", 32'he, par_seen);
    external_parity_present_n <= 1'b1;
    // Internal refresh: twenty clocks apart, 203 clocks between the two snapshots
    apb(1'b0, REG_STAT, 32'h0);
    c0 = q[15:0];
    repeat (200) @(posedge clk);
    apb(1'b0, REG_STAT, 32'h0);
    chk("refresh rate", 32'h1, (q[15:0] - c0 >= 10) && (q[15:0] - c0 <= 11));
    // External refresh: one cycle per request, none of its own
    apb(1'b1, REG_CFG, cfgv(5'd0, 3'd0, 3'd0) | 32'h8000);
    repeat (20) @(posedge clk);
    apb(1'b0, REG_STAT, 32'h0);
    c0 = q[15:0];
    // Request held at least one read cycle time, as external logic must
    ext_ref_n <= 1'b0;
    repeat (10) @(posedge clk);
    ext_ref_n <= 1'b1;
    repeat (30) @(posedge clk);
    apb(1'b0, REG_STAT, 32'h0);
    chk("ext refresh", {16'h0, c0 + 16'd1}, {16'h0, q[15:0]});
    give_verdict;
  end

  // Watchdog for a hung handshake
  initial begin
    #(50 * 60000);
    error_cnt++;
    give_verdict;
  end
endmodule : adbc_top_test
